// ### src/temp_regs_pkg.sv
package temp_regs_pkg;
    localparam int PTR_W = 2;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int RESULT_W = 12;
    localparam int PAD_W = WORD_W - RESULT_W;
    localparam logic [PTR_W-1:0] PTR_TEMP = 2'h0;
    localparam logic [PTR_W-1:0] PTR_CONF = 2'h1;
    localparam logic [PTR_W-1:0] PTR_LOW = 2'h2;
    localparam logic [PTR_W-1:0] PTR_HIGH = 2'h3;
    localparam logic [PTR_W-1:0] PTR_RESET = 2'h0;
    localparam logic [WORD_W-1:0] TEMP_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] CONF_RESET = 8'h28;
    localparam logic [WORD_W-1:0] LOW_RESET = 16'h4B00;
    localparam logic [WORD_W-1:0] HIGH_RESET = 16'h5000;
    localparam logic [PAD_W-1:0] PAD_ZERO = 4'h0;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BYTE_W-PTR_W-1:0] PTR_UPPER_ZERO = 6'h00;
    typedef logic [BYTE_W-1:0] byte_t;
endpackage : temp_regs_pkg

// ### src/temp_regs_if.sv
`timescale 1ns/10ps
// byte-level command channel between the bus controller and the register bank
interface temp_regs_if;
    import temp_regs_pkg::*;
    logic start;
    logic ptr_valid;
    byte_t ptr_byte;
    logic wr_valid;
    byte_t wr_byte;
    logic rd_req;
    logic rd_valid;
    byte_t rd_byte;
    logic stop;
    modport device (input start, input ptr_valid, input ptr_byte, input wr_valid,
        input wr_byte, input rd_req, input stop, output rd_valid, output rd_byte);
    modport controller (output start, output ptr_valid, output ptr_byte, output wr_valid,
        output wr_byte, output rd_req, output stop, input rd_valid, input rd_byte);
endinterface : temp_regs_if

// ### src/temp_regs_device.sv
`timescale 1ns/10ps
// Notes on behaviour
// - two-bit pointer picks one of four registers
// - controller sends pointer byte, upper six zero
// - pointer latched from command, held until replaced
// - read without pointer returns latched register
// - controller sends pointer before changing read target
// - every write carries pointer before data
// - pointer clears to zero at power-up
// - controller avoids reserved pointer codes
// - pointer itself is never readable
// - result is read-only, two bytes
// - result reloads at each conversion end
// - result is 12-bit two's complement
// - result left-aligned, low nibble zero
// - controller collects both bytes, uses 12
// - result reads zero until first conversion
// - configuration byte read/write, resets 28h
// - low limit read/write, resets 4B00h
// - high limit read/write, resets 5000h
// - two-byte registers move MSB first
// - limits stored in result layout
module temp_regs_device
(
    input wire logic sys_clk, // 25 MHz clock
    input wire logic reset, // async, active high
    temp_regs_if.device bus, // command channel
    input wire logic conv_done, // one-cycle pulse: conversion finished
    input wire logic [temp_regs_pkg::RESULT_W-1:0] conv_result, // converter result
    output logic [temp_regs_pkg::BYTE_W-1:0] config_out, // configuration byte
    output logic [temp_regs_pkg::WORD_W-1:0] low_limit_out, // low limit word
    output logic [temp_regs_pkg::WORD_W-1:0] high_limit_out // high limit word
);
    import temp_regs_pkg::*;

    logic [PTR_W-1:0] ptr_ff, nxt_ptr;
    logic [WORD_W-1:0] temp_ff, nxt_temp;
    logic [BYTE_W-1:0] conf_ff, nxt_conf;
    logic [WORD_W-1:0] low_ff, nxt_low;
    logic [WORD_W-1:0] high_ff, nxt_high;
    logic byte_idx_ff, nxt_byte_idx;
    logic rd_valid_ff, nxt_rd_valid;
    byte_t rd_byte_ff, nxt_rd_byte;
    logic take_wr;
    logic take_rd;

    // keeps the 12 result bits, forces the pad nibble to zero
    function automatic logic [WORD_W-1:0] align_word(input logic [WORD_W-1:0] w);
        align_word = {w[WORD_W-1:PAD_W], PAD_ZERO};
    endfunction : align_word

    // places one data byte into a two-byte limit, MSB first
    function automatic logic [WORD_W-1:0] merge_byte(input logic [WORD_W-1:0] w,
        input byte_t b, input logic second);
        if (second) begin
            merge_byte = align_word({w[WORD_W-1:BYTE_W], b});
        end else begin
            // the MSB lands at once; a transfer cut here keeps the old LSB
            merge_byte = {b, w[BYTE_W-1:0]};
        end
    endfunction : merge_byte

    // pointer byte wins over data, data wins over a read request
    always_comb begin
        take_wr = bus.wr_valid && !bus.ptr_valid;
        take_rd = bus.rd_req && !bus.ptr_valid && !bus.wr_valid;
    end

    always_comb begin
        nxt_ptr = ptr_ff;
        if (bus.ptr_valid) begin
            // upper bits are ignored; only the two select bits are kept
            nxt_ptr = bus.ptr_byte[PTR_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ptr_ff <= PTR_RESET;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    // only a finished conversion loads the result; writes never reach it
    always_comb begin
        nxt_temp = temp_ff;
        if (conv_done) begin
            nxt_temp = {conv_result, PAD_ZERO};
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            temp_ff <= TEMP_RESET;
        end else begin
            temp_ff <= nxt_temp;
        end
    end

    // one byte only: a second data byte in the same transfer overwrites the first
    always_comb begin
        nxt_conf = conf_ff;
        if (take_wr && ptr_ff == PTR_CONF) begin
            nxt_conf = bus.wr_byte;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            conf_ff <= CONF_RESET;
        end else begin
            conf_ff <= nxt_conf;
        end
    end

    // limits share the result layout, so the pad nibble is never stored
    always_comb begin
        nxt_low = low_ff;
        if (take_wr && ptr_ff == PTR_LOW) begin
            nxt_low = merge_byte(low_ff, bus.wr_byte, byte_idx_ff);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            low_ff <= LOW_RESET;
        end else begin
            low_ff <= nxt_low;
        end
    end

    always_comb begin
        nxt_high = high_ff;
        if (take_wr && ptr_ff == PTR_HIGH) begin
            nxt_high = merge_byte(high_ff, bus.wr_byte, byte_idx_ff);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            high_ff <= HIGH_RESET;
        end else begin
            high_ff <= nxt_high;
        end
    end

    // counts bytes within a transfer so two-byte registers pair MSB then LSB
    always_comb begin
        nxt_byte_idx = byte_idx_ff;
        if (bus.ptr_valid) begin
            nxt_byte_idx = 1'b0;
        end else if (take_wr) begin
            nxt_byte_idx = ~byte_idx_ff;
        end else if (take_rd) begin
            // single-byte configuration repeats its byte on further reads
            nxt_byte_idx = (ptr_ff == PTR_CONF) ? 1'b0 : ~byte_idx_ff;
        end else if (bus.start || bus.stop) begin
            nxt_byte_idx = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            byte_idx_ff <= 1'b0;
        end else begin
            byte_idx_ff <= nxt_byte_idx;
        end
    end

    // the answer byte is held between answers, so a slow reader still sees it
    always_comb begin
        logic [WORD_W-1:0] sel_word;
        sel_word = TEMP_RESET;
        nxt_rd_valid = 1'b0;
        nxt_rd_byte = rd_byte_ff;
        if (take_rd) begin
            // the pointer never appears on the read path
            if (ptr_ff == PTR_TEMP) begin
                sel_word = temp_ff;
            end else if (ptr_ff == PTR_CONF) begin
                sel_word = {conf_ff, BYTE_ZERO};
            end else if (ptr_ff == PTR_LOW) begin
                sel_word = low_ff;
            end else begin
                sel_word = high_ff;
            end
            nxt_rd_byte = byte_idx_ff ? sel_word[BYTE_W-1:0] : sel_word[WORD_W-1:BYTE_W];
            nxt_rd_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_valid_ff <= 1'b0;
            rd_byte_ff <= BYTE_ZERO;
        end else begin
            rd_valid_ff <= nxt_rd_valid;
            rd_byte_ff <= nxt_rd_byte;
        end
    end

    assign bus.rd_valid = rd_valid_ff;
    assign bus.rd_byte = rd_byte_ff;
    assign config_out = conf_ff;
    assign low_limit_out = low_ff;
    assign high_limit_out = high_ff;
endmodule : temp_regs_device

// ### src/temp_regs_controller.sv
`timescale 1ns/10ps
// user issues whole register transfers; this end breaks them into bytes
module temp_regs_controller
(
    input wire logic sys_clk, // 25 MHz clock
    input wire logic reset, // async, active high
    temp_regs_if.controller bus, // command channel
    input wire logic cmd_valid, // one-cycle pulse: start transfer
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic cmd_use_ptr, // send pointer byte (forced on writes)
    input wire logic [temp_regs_pkg::PTR_W-1:0] cmd_ptr, // register select
    input wire logic [temp_regs_pkg::WORD_W-1:0] cmd_wdata, // write word, MSB first
    output logic cmd_busy, // transfer in progress
    output logic done, // one-cycle pulse: transfer finished
    output logic [temp_regs_pkg::WORD_W-1:0] rdata // read word
);
    import temp_regs_pkg::*;

    typedef enum logic [2:0] {IDLE, PTR, DATA_HI, DATA_LO, WAIT_HI, WAIT_LO, FIN} state_e;

    state_e st_ff, nxt_st;
    logic wr_ff, nxt_wr;
    logic one_byte_ff, nxt_one_byte;
    logic [PTR_W-1:0] ptr_ff, nxt_ptr;
    logic [WORD_W-1:0] word_ff, nxt_word;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic start_ff, nxt_start, pv_ff, nxt_pv, wv_ff, nxt_wv, rq_ff, nxt_rq, stop_ff, nxt_stop;
    byte_t pb_ff, nxt_pb, wb_ff, nxt_wb;

    always_comb begin
        nxt_st = st_ff;
        nxt_wr = wr_ff;
        nxt_one_byte = one_byte_ff;
        nxt_ptr = ptr_ff;
        nxt_word = word_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_start = 1'b0;
        nxt_pv = 1'b0;
        nxt_wv = 1'b0;
        nxt_rq = 1'b0;
        nxt_stop = 1'b0;
        nxt_pb = pb_ff;
        nxt_wb = wb_ff;
        case (st_ff)
            IDLE: begin
                if (cmd_valid) begin
                    nxt_wr = cmd_write;
                    nxt_ptr = cmd_ptr;
                    nxt_one_byte = (cmd_ptr == PTR_CONF);
                    nxt_word = cmd_wdata;
                    nxt_busy = 1'b1;
                    nxt_start = 1'b1;
                    // writes always name their target first
                    nxt_st = (cmd_write || cmd_use_ptr) ? PTR : DATA_HI;
                end
            end
            PTR: begin
                nxt_pv = 1'b1;
                nxt_pb = {PTR_UPPER_ZERO, ptr_ff};
                nxt_st = DATA_HI;
            end
            DATA_HI: begin
                if (wr_ff) begin
                    nxt_wv = 1'b1;
                    nxt_wb = one_byte_ff ? word_ff[BYTE_W-1:0] : word_ff[WORD_W-1:BYTE_W];
                    nxt_st = one_byte_ff ? FIN : DATA_LO;
                end else begin
                    nxt_rq = 1'b1;
                    nxt_st = WAIT_HI;
                end
            end
            DATA_LO: begin
                nxt_wv = 1'b1;
                nxt_wb = word_ff[BYTE_W-1:0];
                nxt_st = FIN;
            end
            WAIT_HI: begin
                if (bus.rd_valid) begin
                    if (one_byte_ff) begin
                        nxt_word = {BYTE_ZERO, bus.rd_byte};
                        nxt_st = FIN;
                    end else begin
                        nxt_word = {bus.rd_byte, BYTE_ZERO};
                        nxt_rq = 1'b1;
                        nxt_st = WAIT_LO;
                    end
                end
            end
            WAIT_LO: begin
                if (bus.rd_valid) begin
                    nxt_word = {word_ff[WORD_W-1:BYTE_W], bus.rd_byte};
                    nxt_st = FIN;
                end
            end
            default: begin
                nxt_stop = 1'b1;
                nxt_done = 1'b1;
                nxt_busy = 1'b0;
                nxt_st = IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_ff <= IDLE;
            wr_ff <= 1'b0;
            one_byte_ff <= 1'b0;
            ptr_ff <= PTR_RESET;
            word_ff <= TEMP_RESET;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            start_ff <= 1'b0;
            pv_ff <= 1'b0;
            wv_ff <= 1'b0;
            rq_ff <= 1'b0;
            stop_ff <= 1'b0;
            pb_ff <= BYTE_ZERO;
            wb_ff <= BYTE_ZERO;
        end else begin
            st_ff <= nxt_st;
            wr_ff <= nxt_wr;
            one_byte_ff <= nxt_one_byte;
            ptr_ff <= nxt_ptr;
            word_ff <= nxt_word;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            start_ff <= nxt_start;
            pv_ff <= nxt_pv;
            wv_ff <= nxt_wv;
            rq_ff <= nxt_rq;
            stop_ff <= nxt_stop;
            pb_ff <= nxt_pb;
            wb_ff <= nxt_wb;
        end
    end

    assign bus.start = start_ff;
    assign bus.ptr_valid = pv_ff;
    assign bus.ptr_byte = pb_ff;
    assign bus.wr_valid = wv_ff;
    assign bus.wr_byte = wb_ff;
    assign bus.rd_req = rq_ff;
    assign bus.stop = stop_ff;
    assign cmd_busy = busy_ff;
    assign done = done_ff;
    assign rdata = word_ff;
endmodule : temp_regs_controller

// ### bench/temp_regs_monitor.sv
`timescale 1ns/10ps
module temp_regs_monitor
    import temp_regs_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic reset, // async, active high
    input wire logic start, // transfer begins
    input wire logic ptr_valid, // pointer byte strobe
    input wire temp_regs_pkg::byte_t ptr_byte, // pointer byte
    input wire logic wr_valid, // data byte strobe
    input wire temp_regs_pkg::byte_t wr_byte, // data byte
    input wire logic rd_req, // read request
    input wire logic rd_valid, // read answer strobe
    input wire temp_regs_pkg::byte_t rd_byte, // read answer byte
    input wire logic stop // transfer ends
);
    logic [PTR_W-1:0] ptr_ff;
    logic [PTR_W-1:0] nxt_ptr;
    logic idx_ff;
    logic nxt_idx;
    logic seen_ff;
    logic nxt_seen;

    // shadow of the latched pointer and byte index, rebuilt from the wire
    always_comb begin
        nxt_ptr = ptr_valid ? ptr_byte[PTR_W-1:0] : ptr_ff;
        nxt_seen = start ? 1'b0 : (ptr_valid | seen_ff);
        nxt_idx = idx_ff;
        if (start || stop) begin
            nxt_idx = 1'b0;
        end else if (!ptr_valid && (wr_valid || rd_valid)) begin
            nxt_idx = ~idx_ff;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ptr_ff <= PTR_RESET;
            idx_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            ptr_ff <= nxt_ptr;
            idx_ff <= nxt_idx;
            seen_ff <= nxt_seen;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_RD_ANSWER: assert property (rd_req && !ptr_valid && !wr_valid |=> rd_valid)
        else $error("read request not answered in the next cycle");
    AST_RD_CAUSE: assert property (rd_valid |-> $past(rd_req))
        else $error("read answer without a request");
    AST_PTR_FIRST: assert property (ptr_valid |=> !rd_valid)
        else $error("read served in the cycle of a pointer byte");
    AST_WR_FIRST: assert property (wr_valid && !ptr_valid |=> !rd_valid)
        else $error("read served in the cycle of a write byte");
    AST_BYTE_HOLDS: assert property (!rd_valid |-> $stable(rd_byte))
        else $error("read byte moved without an answer");
    AST_LSB_ZERO: assert property (rd_valid && idx_ff && ptr_ff != PTR_CONF
        |-> rd_byte[PAD_W-1:0] == PAD_ZERO)
        else $error("low nibble of second byte not zero");
    AST_WR_HAS_PTR: assert property (wr_valid |-> seen_ff && !start)
        else $error("write byte without pointer byte in transfer");
    AST_PTR_UPPER: assert property (ptr_valid |-> ptr_byte[7:2] == PTR_UPPER_ZERO)
        else $error("pointer byte upper bits not zero");

    cover property (rd_valid && idx_ff);
    cover property (wr_valid && idx_ff);
    cover property (ptr_valid && ptr_byte[1:0] == PTR_HIGH);
endmodule : temp_regs_monitor

// ### bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import temp_regs_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic conv_done = 1'b0;
    logic [RESULT_W-1:0] conv_result = 12'h000;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic cmd_use_ptr = 1'b0;
    logic [PTR_W-1:0] cmd_ptr = 2'h0;
    logic [WORD_W-1:0] cmd_wdata = 16'h0000;
    logic cmd_busy;
    logic done;
    logic [WORD_W-1:0] rdata;
    logic [WORD_W-1:0] low_limit_out;
    logic [WORD_W-1:0] high_limit_out;
    logic [BYTE_W-1:0] config_out;
    logic [RESULT_W-1:0] temps [5] = '{12'h7FF, 12'hE70, 12'hD80, 12'h004, 12'h800};
    int bad_count = 0;
    int num_checks = 0;

    temp_regs_if bus_if();
    temp_regs_device temp_regs_device_inst (.sys_clk(sys_clk), .reset(reset), .bus(bus_if),
        .conv_done(conv_done), .conv_result(conv_result), .config_out(config_out),
        .low_limit_out(low_limit_out), .high_limit_out(high_limit_out));
    temp_regs_controller temp_regs_controller_inst (.sys_clk(sys_clk), .reset(reset),
        .bus(bus_if), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_use_ptr(cmd_use_ptr),
        .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .done(done),
        .rdata(rdata));
    temp_regs_monitor temp_regs_monitor_inst (.sys_clk(sys_clk), .reset(reset),
        .start(bus_if.start), .ptr_valid(bus_if.ptr_valid), .ptr_byte(bus_if.ptr_byte),
        .wr_valid(bus_if.wr_valid), .wr_byte(bus_if.wr_byte), .rd_req(bus_if.rd_req),
        .rd_valid(bus_if.rd_valid), .rd_byte(bus_if.rd_byte), .stop(bus_if.stop));

    always #20 sys_clk = ~sys_clk;

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // one whole register transfer; waits for done with a bound
    task xfer(input logic w, input logic up, input logic [PTR_W-1:0] p,
        input logic [WORD_W-1:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_use_ptr <= up;
        cmd_ptr <= p;
        cmd_wdata <= d;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        #1;
        chk({15'h0000, cmd_busy}, 16'h0001, "busy in transfer");
        while (done !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 50) begin
            bad_count++;
            $display("CHECK FAILED t=%0t transfer never finished", $time);
        end
        chk({15'h0000, cmd_busy}, 16'h0000, "busy after done");
    endtask : xfer

    task rd(input logic up, input logic [PTR_W-1:0] p, input logic [WORD_W-1:0] exp);
        xfer(1'b0, up, p, 16'h0000);
        chk(rdata, exp, "read word");
    endtask : rd

    task conv(input logic [RESULT_W-1:0] v);
        @(posedge sys_clk);
        conv_done <= 1'b1;
        conv_result <= v;
        @(posedge sys_clk);
        conv_done <= 1'b0;
    endtask : conv

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk({8'h00, config_out}, 16'h0028, "conf reset");
        chk(low_limit_out, 16'h4B00, "low reset");
        chk(high_limit_out, 16'h5000, "high reset");
        rd(1'b0, PTR_HIGH, 16'h0000);
        rd(1'b1, PTR_CONF, 16'h0028);
        rd(1'b1, PTR_LOW, 16'h4B00);
        rd(1'b1, PTR_HIGH, 16'h5000);
        rd(1'b0, PTR_TEMP, 16'h5000);
        xfer(1'b1, 1'b1, PTR_HIGH, 16'h7FFF);
        chk(high_limit_out, 16'h7FF0, "high write");
        rd(1'b0, PTR_HIGH, 16'h7FF0);
        xfer(1'b1, 1'b1, PTR_LOW, 16'hE70A);
        rd(1'b1, PTR_LOW, 16'hE700);
        xfer(1'b1, 1'b1, PTR_CONF, 16'h00A5);
        chk({8'h00, config_out}, 16'h00A5, "conf write");
        rd(1'b1, PTR_CONF, 16'h00A5);
        for (int i = 0; i < 5; i++) begin
            conv(temps[i]);
            rd(1'b1, PTR_TEMP, {temps[i], PAD_ZERO});
        end
        xfer(1'b1, 1'b1, PTR_TEMP, 16'h1230);
        rd(1'b1, PTR_TEMP, 16'h8000);
        // conversion ends in the very cycle the dropped MSB write lands
        fork
            xfer(1'b1, 1'b1, PTR_TEMP, 16'h1230);
            begin
                repeat (3) @(posedge sys_clk);
                conv(12'h190);
            end
        join
        rd(1'b1, PTR_TEMP, 16'h1900);
        // second reset in mid-run must restore the pointer, result and low limit defaults
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(1'b0, PTR_LOW, 16'h0000);
        chk(low_limit_out, 16'h4B00, "low after reset");
        end_of_test();
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule : tb_top
